// >>> inc/rx_alarm_pkg.sv
// Purpose: Shared constants and carriers for the receive alarm/counter configuration block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes: Alarm option and latch bit positions and configuration reset values live here
package rx_alarm_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_LOOP_LEN = 8'h42;
  localparam logic [7:0] IDX_ACT_PAT = 8'h43;
  localparam logic [7:0] IDX_DEACT_PAT = 8'h44;
  localparam logic [7:0] IDX_RX_ALARM = 8'h45;
  localparam logic [7:0] IDX_LATCH = 8'h46;
  localparam logic [7:0] IDX_FRAME_ERROR_COUNT_LO = 8'h50;
  localparam logic [7:0] IDX_FRAME_ERROR_COUNT_HI = 8'h51;
  localparam logic [7:0] IDX_LCV_LO = 8'h54;
  localparam logic [7:0] IDX_LCV_HI = 8'h55;
  localparam logic [7:0] IDX_PERR_LO = 8'h58;
  localparam logic [7:0] IDX_PERR_HI = 8'h59;
  localparam logic [7:0] IDX_AEVT = 8'h5A;
  localparam logic [7:0] IDX_IRQ_EN = 8'h60;
  localparam logic [7:0] IDX_ERR_ISR = 8'h61;
  localparam logic [7:0] IDX_ALM_ISR = 8'h62;
  localparam logic [2:0][7:0] CNT_LO_IDX = {IDX_PERR_LO, IDX_LCV_LO, IDX_FRAME_ERROR_COUNT_LO};
  localparam logic [2:0][7:0] CNT_HI_IDX = {IDX_PERR_HI, IDX_LCV_HI, IDX_FRAME_ERROR_COUNT_HI};

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int RA_FRAME_BIT = 5;
  localparam int RA_EXZ = 4;
  localparam int RA_YEL_INT = 3;
  localparam int RA_LOF_INT = 2;
  localparam int RA_FORCE_ONES = 0;
  localparam int LT_STOP = 3;
  localparam int LT_CNT = 2;
  localparam int LT_ERR = 1;
  localparam int LT_ALM = 0;
  localparam logic [7:0] PAT_MASK = 8'hFE;
  localparam logic [7:0] RX_ALARM_MASK = 8'h3D;
  localparam logic [7:0] LATCH_MASK = 8'h0F;
  localparam logic [7:0] LOOP_LEN_MASK = 8'h0F;
  localparam logic [7:0] IRQ_EN_MASK = 8'h77;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int LOF_INTEG_MS = 2250;
  localparam int LOF_INTEG_CYC = int'((64'(LOF_INTEG_MS) * 64'(CLK_HZ)) / 64'd1000);
  localparam int LOF_TMR_W = 25;
  localparam logic [4:0] EXZ_SHORT = 5'h08;
  localparam logic [4:0] EXZ_LONG = 5'h10;
  localparam int CNT_W = 16;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic t1_mode;
    logic one_second_tick;
    logic fas_error;
    logic frame_bit_error;
    logic bpv_event;
    logic line_bit;
    logic line_bit_valid;
    logic zero_substitution_setting;
    logic pattern_bit_error;
    logic raw_loss_of_frame;
    logic loss_of_signal_status;
    logic all_ones_alarm_status;
    logic frame_yellow_raw;
    logic frame_yellow_integ;
    logic mframe_yellow_raw;
    logic mframe_yellow_integ;
    logic rx_pcm_data;
  } rx_in_s;

  typedef struct packed {
    logic [6:0] activate_pattern;
    logic [6:0] activate_mask;
    logic [6:0] deactivate_pattern;
    logic [6:0] deactivate_mask;
    logic frame_bit_inclusion;
    logic frame_yellow_status;
    logic multiframe_yellow_status;
    logic loss_of_frame_status;
    logic counting_stopped;
    logic rx_pcm_output;
  } cfg_out_s;
endpackage

// >>> hw/rx_alarm_counter_config.sv
// Purpose: Receive loopback code, alarm option and error counter latch configuration with AXI4-Lite access
// Assumes: Event inputs come from framer logic on aclk; one_second_tick is a one-cycle enable
// Notes: Counters saturate; interrupt status is software visible only, no interrupt pin
//
// Overview of operation
// - Activate pattern: first bit at bit 7
// - Activate length selects leading bits compared
// - Deactivate pattern same order, own length
// - Length code 00..11 gives 4..7 bits
// - Frame-bit inclusion feeds frame errors, alignment
// - Excess zeros join line code count
// - Yellow integration selects integrated yellow status
// - T1 loss-of-frame integration over 2.25 s
// - Integration leaves raw event counts and count stop alone
// - Force ones replaces receive PCM output
// - Count stop freezes counters during alarms
// - Pattern and alarm event counters ignore stop
// - Latching snapshots counts on each one-second tick
// - Unlatched low read copies high, clears
// - E1 mode forces counter latching on
// - Error status rising edge, one-second hold
// - Alarm status transition, one-second hold
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module rx_alarm_counter_config #(
  parameter int unsigned LOF_INTEG_CYCLES = rx_alarm_pkg::LOF_INTEG_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rx_alarm_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [rx_alarm_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire rx_alarm_pkg::rx_in_s rx_in,
  output rx_alarm_pkg::cfg_out_s status_out
);
  import rx_alarm_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [6:0] len_mask(input logic [1:0] len);
    case (len)
      2'b00: len_mask = 7'h78;
      2'b01: len_mask = 7'h7C;
      2'b10: len_mask = 7'h7E;
      default: len_mask = 7'h7F;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] sat_add(input logic [CNT_W-1:0] v, input logic [1:0] n);
    logic [CNT_W:0] s;
    s = {1'b0, v} + {{(CNT_W-1){1'b0}}, n};
    sat_add = s[CNT_W] ? {CNT_W{1'b1}} : s[CNT_W-1:0];
  endfunction

  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx >= IDX_LOOP_LEN && idx <= IDX_LATCH) || idx == IDX_FRAME_ERROR_COUNT_LO || idx == IDX_FRAME_ERROR_COUNT_HI ||
             idx == IDX_LCV_LO || idx == IDX_LCV_HI || idx == IDX_PERR_LO || idx == IDX_PERR_HI ||
             idx == IDX_AEVT || (idx >= IDX_IRQ_EN && idx <= IDX_ALM_ISR);
  endfunction

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  // Read side effects act at the address handshake, so rdata holds the value before any clear
  logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] rd_byte;

  wire aw_hs = awvalid & awready_q;
  wire w_hs = wvalid & wready_q;
  wire ar_hs = arvalid & arready_q;
  wire do_wr = aw_have_q & w_have_q & ~bvalid_q;
  wire [7:0] widx = awaddr_q[ADDR_W-1:2];
  wire [7:0] ridx = araddr[ADDR_W-1:2];
  wire wr_en = do_wr & wlane_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (aw_hs) begin
        aw_have_q <= 1'b1;
        awaddr_q <= awaddr;
      end else if (do_wr) begin
        aw_have_q <= 1'b0;
      end
      if (w_hs) begin
        w_have_q <= 1'b1;
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end else if (do_wr) begin
        w_have_q <= 1'b0;
      end
      awready_q <= ~(aw_hs | (aw_have_q & ~do_wr));
      wready_q <= ~(w_hs | (w_have_q & ~do_wr));
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q <= mapped(widx) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
      arready_q <= ~(ar_hs | (rvalid_q & ~rready));
      if (ar_hs) begin
        rvalid_q <= 1'b1;
        rdata_q <= {24'h00_0000, rd_byte};
        rresp_q <= mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // ****************************************
  // Configuration registers
  // ****************************************
  // Undefined bits are masked on write so they always read back as zero
  logic [7:0] loop_len_q, act_q, deact_q, rx_alarm_q, latch_q, irq_en_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_len_q <= REG_RESET;
      act_q <= REG_RESET;
      deact_q <= REG_RESET;
      rx_alarm_q <= REG_RESET;
      latch_q <= REG_RESET;
      irq_en_q <= REG_RESET;
    end else if (wr_en) begin
      case (widx)
        IDX_LOOP_LEN: loop_len_q <= wbyte_q & LOOP_LEN_MASK;
        IDX_ACT_PAT: act_q <= wbyte_q & PAT_MASK;
        IDX_DEACT_PAT: deact_q <= wbyte_q & PAT_MASK;
        IDX_RX_ALARM: rx_alarm_q <= wbyte_q & RX_ALARM_MASK;
        IDX_LATCH: latch_q <= wbyte_q & LATCH_MASK;
        IDX_IRQ_EN: irq_en_q <= wbyte_q & IRQ_EN_MASK;
        default: ;
      endcase
    end
  end

  wire tick = rx_in.one_second_tick;
  wire lat_cnt = latch_q[LT_CNT] | ~rx_in.t1_mode;
  wire [2:0] ie_err = irq_en_q[2:0];
  wire [2:0] ie_alm = irq_en_q[6:4];

  // ****************************************
  // Excess zero detector
  // ****************************************
  // Run restarts after each event, so a long zero run counts once per limit
  logic [4:0] zrun_q;
  logic exz_q;
  wire [4:0] exz_limit = rx_in.zero_substitution_setting ? EXZ_SHORT : EXZ_LONG;
  wire zrun_full = (zrun_q + 5'h01) == exz_limit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zrun_q <= 5'h00;
      exz_q <= 1'b0;
    end else begin
      exz_q <= rx_in.line_bit_valid & ~rx_in.line_bit & zrun_full;
      if (rx_in.line_bit_valid) begin
        zrun_q <= (rx_in.line_bit | zrun_full) ? 5'h00 : zrun_q + 5'h01;
      end
    end
  end

  // ****************************************
  // Loss of frame integration
  // ****************************************
  // Timer restarts whenever raw returns to the reported state; short glitches never show
  logic lof_int_q;
  logic [LOF_TMR_W-1:0] lof_tmr_q;
  wire lof_raw = rx_in.raw_loss_of_frame;
  wire lof_done = lof_tmr_q == LOF_TMR_W'(LOF_INTEG_CYCLES - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lof_int_q <= 1'b0;
      lof_tmr_q <= '0;
    end else if (lof_raw == lof_int_q) begin
      lof_tmr_q <= '0;
    end else if (lof_done) begin
      lof_int_q <= lof_raw;
      lof_tmr_q <= '0;
    end else begin
      lof_tmr_q <= lof_tmr_q + LOF_TMR_W'(1);
    end
  end

  wire lof_status = (rx_alarm_q[RA_LOF_INT] & rx_in.t1_mode) ? lof_int_q : lof_raw;
  wire fy_status = rx_alarm_q[RA_YEL_INT] ? rx_in.frame_yellow_integ : rx_in.frame_yellow_raw;
  wire mfy_status = rx_alarm_q[RA_YEL_INT] ? rx_in.mframe_yellow_integ : rx_in.mframe_yellow_raw;

  // ****************************************
  // Error counters
  // ****************************************
  // Stop uses the raw framer loss so integration cannot delay it
  wire stop = latch_q[LT_STOP] & (lof_raw | rx_in.loss_of_signal_status | rx_in.all_ones_alarm_status);
  wire fb_err = rx_alarm_q[RA_FRAME_BIT] & rx_in.frame_bit_error;
  wire lcv_exz = rx_alarm_q[RA_EXZ] & exz_q;
  wire [2:0][1:0] inc = {{1'b0, rx_in.pattern_bit_error},
                         {1'b0, rx_in.bpv_event} + {1'b0, lcv_exz},
                         {1'b0, rx_in.fas_error} + {1'b0, fb_err}};
  wire [2:0] run = {1'b1, ~stop, ~stop};
  wire [2:0] rd_lo, rd_hi;
  logic [2:0][CNT_W-1:0] cnt_q, hold_q;
  logic [2:0][7:0] msb_q;

  for (genvar k = 0; k < 3; k++) begin : g_cnt
    assign rd_lo[k] = ar_hs & ridx == CNT_LO_IDX[k];
    assign rd_hi[k] = ar_hs & ridx == CNT_HI_IDX[k];
    wire [1:0] add = run[k] ? inc[k] : 2'b00;
    wire [CNT_W-1:0] base = (tick & lat_cnt) ? '0 :
                            (rd_lo[k] & ~lat_cnt) ? {cnt_q[k][15:8], 8'h00} :
                            (rd_hi[k] & ~lat_cnt) ? {8'h00, cnt_q[k][7:0]} : cnt_q[k];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_q[k] <= '0;
        hold_q[k] <= '0;
        msb_q[k] <= 8'h00;
      end else begin
        cnt_q[k] <= sat_add(base, add);
        if (tick & lat_cnt) begin
          hold_q[k] <= cnt_q[k];
        end
        if (rd_lo[k] & ~lat_cnt) begin
          msb_q[k] <= cnt_q[k][15:8];
        end else if (rd_hi[k] & ~lat_cnt) begin
          msb_q[k] <= 8'h00;
        end
      end
    end
  end

  // Alarm events come from raw loss of frame and are never stopped
  logic [7:0] aevt_q;
  logic lof_raw_q;
  wire rd_aevt = ar_hs & ridx == IDX_AEVT;
  wire aevt_inc = lof_raw & ~lof_raw_q;
  wire [7:0] aevt_base = rd_aevt ? 8'h00 : aevt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aevt_q <= 8'h00;
      lof_raw_q <= 1'b0;
    end else begin
      lof_raw_q <= lof_raw;
      if (aevt_inc && aevt_base != 8'hFF) begin
        aevt_q <= aevt_base + 8'h01;
      end else begin
        aevt_q <= aevt_base;
      end
    end
  end

  // ****************************************
  // Interrupt status latching
  // ****************************************
  // Set wins over a clear in the same cycle so no event is lost
  logic [2:0] err_prev_q, alm_prev_q, err_isr_q, alm_isr_q;
  wire [2:0] err_now = {rx_in.pattern_bit_error, |inc[1], |inc[0]};
  wire [2:0] alm_now = {mfy_status, fy_status, lof_status};
  wire [2:0] err_rise = err_now & ~err_prev_q;
  wire [2:0] alm_edge = alm_now ^ alm_prev_q;
  wire rd_err = ar_hs & ridx == IDX_ERR_ISR;
  wire rd_alm = ar_hs & ridx == IDX_ALM_ISR;
  // Disabled bits with latching on are held one interval; read does not clear them
  wire [2:0] err_sec = ~ie_err & {3{latch_q[LT_ERR]}};
  wire [2:0] alm_sec = ~ie_alm & {3{latch_q[LT_ALM]}};
  wire [2:0] err_clr = ({3{tick}} & err_sec) | ({3{rd_err}} & ~err_sec);
  wire [2:0] alm_clr = ({3{tick}} & alm_sec) | ({3{rd_alm}} & ~alm_sec);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_prev_q <= 3'h0;
      alm_prev_q <= 3'h0;
      err_isr_q <= 3'h0;
      alm_isr_q <= 3'h0;
    end else begin
      err_prev_q <= err_now;
      alm_prev_q <= alm_now;
      err_isr_q <= (err_isr_q & ~err_clr) | err_rise;
      alm_isr_q <= (alm_isr_q & ~alm_clr) | alm_edge;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    case (ridx)
      IDX_LOOP_LEN: rd_byte = loop_len_q;
      IDX_ACT_PAT: rd_byte = act_q;
      IDX_DEACT_PAT: rd_byte = deact_q;
      IDX_RX_ALARM: rd_byte = rx_alarm_q;
      IDX_LATCH: rd_byte = latch_q;
      IDX_FRAME_ERROR_COUNT_LO: rd_byte = lat_cnt ? hold_q[0][7:0] : cnt_q[0][7:0];
      IDX_FRAME_ERROR_COUNT_HI: rd_byte = lat_cnt ? hold_q[0][15:8] : msb_q[0];
      IDX_LCV_LO: rd_byte = lat_cnt ? hold_q[1][7:0] : cnt_q[1][7:0];
      IDX_LCV_HI: rd_byte = lat_cnt ? hold_q[1][15:8] : msb_q[1];
      IDX_PERR_LO: rd_byte = lat_cnt ? hold_q[2][7:0] : cnt_q[2][7:0];
      IDX_PERR_HI: rd_byte = lat_cnt ? hold_q[2][15:8] : msb_q[2];
      IDX_AEVT: rd_byte = aevt_q;
      IDX_IRQ_EN: rd_byte = irq_en_q;
      IDX_ERR_ISR: rd_byte = {5'h00, err_isr_q};
      IDX_ALM_ISR: rd_byte = {5'h00, alm_isr_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // ****************************************
  // Outputs to detectors and receive path
  // ****************************************
  cfg_out_s out_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= '0;
    end else begin
      out_q.activate_pattern <= act_q[7:1];
      out_q.activate_mask <= len_mask(loop_len_q[1:0]);
      out_q.deactivate_pattern <= deact_q[7:1];
      out_q.deactivate_mask <= len_mask(loop_len_q[3:2]);
      out_q.frame_bit_inclusion <= rx_alarm_q[RA_FRAME_BIT];
      out_q.frame_yellow_status <= fy_status;
      out_q.multiframe_yellow_status <= mfy_status;
      out_q.loss_of_frame_status <= lof_status;
      out_q.counting_stopped <= stop;
      out_q.rx_pcm_output <= rx_alarm_q[RA_FORCE_ONES] | rx_in.rx_pcm_data;
    end
  end

  assign status_out = out_q;
endmodule

// >>> tb/rx_alarm_counter_config_props.sv
// Purpose: Port-level checks of rx_alarm_counter_config
// Assumes: Status outputs follow their inputs by one register stage
// Notes: Bound to every instance of the design below
`timescale 1ns/1ps
module rx_alarm_counter_config_props
  import rx_alarm_pkg::*;
#(
  parameter int unsigned LOF_INTEG_CYCLES = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire rx_in_s rx_in,
  input wire cfg_out_s status_out
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  property p_wr_resp;
    s_wr_both |-> ##[1:2] bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_rd_resp;
    s_rd_take |-> ##[1:2] rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_rdata_hi;
    rvalid |-> rdata[31:8] == 24'h00_0000;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
  // Data high can only give high, whatever the force bit holds
  property p_force;
    $past(aresetn) && $past(rx_in.rx_pcm_data) |-> status_out.rx_pcm_output;
  endproperty
  a_force: assert property (p_force) else $error("pcm data lost");
  property p_mask;
    $past(aresetn) |-> status_out.activate_mask inside {7'h78, 7'h7C, 7'h7E, 7'h7F}
      && status_out.deactivate_mask inside {7'h78, 7'h7C, 7'h7E, 7'h7F};
  endproperty
  a_mask: assert property (p_mask) else $error("bad compare mask");
  property p_nostop;
    $past(aresetn) && !$past(rx_in.raw_loss_of_frame || rx_in.loss_of_signal_status
      || rx_in.all_ones_alarm_status) |-> !status_out.counting_stopped;
  endproperty
  a_nostop: assert property (p_nostop) else $error("counts stopped without alarm");
  property p_yellow;
    $past(aresetn) && $past(rx_in.frame_yellow_raw) == $past(rx_in.frame_yellow_integ)
      |-> status_out.frame_yellow_status == $past(rx_in.frame_yellow_raw);
  endproperty
  a_yellow: assert property (p_yellow) else $error("yellow status wrong");
  property p_e1_lof;
    $past(aresetn) && !$past(rx_in.t1_mode)
      |-> status_out.loss_of_frame_status == $past(rx_in.raw_loss_of_frame);
  endproperty
  a_e1_lof: assert property (p_e1_lof) else $error("frame loss integrated in E1");
endmodule

bind rx_alarm_counter_config rx_alarm_counter_config_props #(
  .LOF_INTEG_CYCLES(LOF_INTEG_CYCLES)
) u_props (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rvalid, .rready, .rx_in, .status_out
);

// >>> tb/tb_rx_alarm_counter_config.sv
// Purpose: Register-level tests of rx_alarm_counter_config
// Assumes: Short integration count of 20 cycles
// Notes: Events are one-cycle pulses on the system clock
`timescale 1ns/1ps
module tb_rx_alarm_counter_config;
  import rx_alarm_pkg::*;
  localparam int LOF_CYC = 20;
  localparam rx_in_s M_FAS = '{fas_error: 1'b1, default: 1'b0};
  localparam rx_in_s M_FB = '{frame_bit_error: 1'b1, default: 1'b0};
  localparam rx_in_s M_BPV = '{bpv_event: 1'b1, default: 1'b0};
  localparam rx_in_s M_LBV = '{line_bit_valid: 1'b1, default: 1'b0};
  localparam rx_in_s M_PAT = '{pattern_bit_error: 1'b1, default: 1'b0};
  localparam rx_in_s M_TICK = '{one_second_tick: 1'b1, default: 1'b0};
  localparam rx_in_s M_LOF = '{raw_loss_of_frame: 1'b1, default: 1'b0};
  localparam rx_in_s M_FY = '{frame_yellow_raw: 1'b1, default: 1'b0};
  localparam rx_in_s M_MI = '{mframe_yellow_integ: 1'b1, default: 1'b0};
  localparam rx_in_s M_T1 = '{t1_mode: 1'b1, default: 1'b0};
  localparam rx_in_s M_ZS = '{zero_substitution_setting: 1'b1, default: 1'b0};
  localparam rx_in_s M_PCM = '{rx_pcm_data: 1'b1, default: 1'b0};
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, late = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, rsp;
  logic [7:0] rv;
  rx_in_s ri = rx_in_s'(M_T1 | M_ZS);
  cfg_out_s so;
  int fail_count = 0, checks = 0;
  logic [7:0] ix_t [5] = '{IDX_LOOP_LEN, IDX_ACT_PAT, IDX_DEACT_PAT, IDX_RX_ALARM, IDX_LATCH};
  logic [7:0] mk_t [5] = '{LOOP_LEN_MASK, PAT_MASK, PAT_MASK, RX_ALARM_MASK, LATCH_MASK};

  always #50 aclk = ~aclk;

  rx_alarm_counter_config #(.LOF_INTEG_CYCLES(LOF_CYC)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rx_in(ri), .status_out(so)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic set(input rx_in_s m, input logic v);
    ri <= v ? rx_in_s'(ri | m) : rx_in_s'(ri & ~m);
    @(posedge aclk);
  endtask
  task automatic ev(input rx_in_s m, input int n);
    repeat (n) begin
      set(m, 1'b1);
      set(m, 1'b0);
    end
  endtask
  // Each bus task starts on a fresh edge so no signal is driven twice in one step
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {ix, 2'b00};
    wdata <= 32'(d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !late;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ix);
    @(posedge aclk);
    araddr <= {ix, 2'b00};
    arvalid <= 1'b1;
    rready <= !late;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    rv = rdata[7:0];
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [7:0] ix, input logic [7:0] e);
    rd(ix);
    chk($sformatf("reg %h", ix), 32'(rv), 32'(e));
    chk("rresp", rsp, RESP_OKAY);
  endtask
  task automatic summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    wt(4);
    aresetn <= 1'b1;
    foreach (ix_t[i]) begin
      rc(ix_t[i], REG_RESET);
      wr(ix_t[i], ix_t[i] == IDX_RX_ALARM ? 8'hFD : 8'hFF);
      rc(ix_t[i], mk_t[i]);
    end
    wr(IDX_ACT_PAT, 8'hA5);
    wr(IDX_DEACT_PAT, 8'h5B);
    wt(3);
    chk("act", so.activate_pattern, 7'h52);
    chk("deact", so.deactivate_pattern, 7'h2D);
    rc(IDX_ACT_PAT, 8'hA4);
    for (int u = 0; u < 4; u++) begin
      wr(IDX_LOOP_LEN, 8'(((3 - u) << 2) | u));
      wt(3);
      chk("amask", so.activate_mask, 7'(7'h7F << (3 - u)));
      chk("dmask", so.deactivate_mask, 7'(7'h7F << u));
    end
    wr(8'h30, 8'h01);
    chk("bresp", rsp, RESP_SLVERR);
    wr(IDX_LATCH, 8'h00);
    chk("bresp", rsp, RESP_OKAY);
    wr(IDX_RX_ALARM, 8'h01);
    wt(3);
    chk("pcm", so.rx_pcm_output, 1'b1);
    wr(IDX_RX_ALARM, 8'h30);
    wt(3);
    chk("pcm", so.rx_pcm_output, 1'b0);
    chk("fbi", so.frame_bit_inclusion, 1'b1);
    set(M_PCM, 1'b1);
    wt(2);
    chk("pcm", so.rx_pcm_output, 1'b1);
    set(M_PCM, 1'b0);
    // 263 frame errors cross the byte boundary
    ev(M_FAS, 260);
    ev(M_FB, 3);
    ev(M_LBV, 8);
    ev(M_BPV, 1);
    wt(3);
    rc(IDX_FRAME_ERROR_COUNT_LO, 8'h07);
    rc(IDX_FRAME_ERROR_COUNT_HI, 8'h01);
    rc(IDX_FRAME_ERROR_COUNT_LO, 8'h00);
    rc(IDX_LCV_LO, 8'h02);
    wr(IDX_RX_ALARM, 8'h08);
    set(M_FY, 1'b1);
    set(M_MI, 1'b1);
    wt(3);
    chk("fy", so.frame_yellow_status, 1'b0);
    chk("my", so.multiframe_yellow_status, 1'b1);
    wr(IDX_RX_ALARM, 8'h00);
    wt(3);
    chk("fy", so.frame_yellow_status, 1'b1);
    chk("my", so.multiframe_yellow_status, 1'b0);
    set(M_FY, 1'b0);
    set(M_MI, 1'b0);
    wr(IDX_LATCH, 8'h08);
    set(M_LOF, 1'b1);
    wt(3);
    chk("stop", so.counting_stopped, 1'b1);
    ev(M_FAS, 1);
    ev(M_PAT, 1);
    wt(3);
    rc(IDX_FRAME_ERROR_COUNT_LO, 8'h00);
    rc(IDX_PERR_LO, 8'h01);
    rc(IDX_AEVT, 8'h01);
    set(M_LOF, 1'b0);
    wt(3);
    chk("stop", so.counting_stopped, 1'b0);
    wr(IDX_LATCH, 8'h00);
    rd(IDX_ERR_ISR);
    wr(IDX_LATCH, 8'h02);
    ev(M_BPV, 1);
    wt(3);
    rc(IDX_ERR_ISR, 8'h02);
    rc(IDX_ERR_ISR, 8'h02);
    ev(M_TICK, 1);
    wt(3);
    rc(IDX_ERR_ISR, 8'h00);
    wr(IDX_LATCH, 8'h04);
    ev(M_FAS, 3);
    ev(M_TICK, 1);
    ev(M_FAS, 1);
    wt(3);
    rc(IDX_FRAME_ERROR_COUNT_LO, 8'h03);
    wr(IDX_LATCH, 8'h00);
    wr(IDX_RX_ALARM, 8'h04);
    set(M_LOF, 1'b1);
    wt(5);
    chk("lof", so.loss_of_frame_status, 1'b0);
    wt(LOF_CYC + 5);
    chk("lof", so.loss_of_frame_status, 1'b1);
    set(M_T1, 1'b0);
    set(M_LOF, 1'b0);
    wt(3);
    chk("lof", so.loss_of_frame_status, 1'b0);
    rc(IDX_ALM_ISR, 8'h07);
    rc(IDX_ALM_ISR, 8'h00);
    wr(IDX_LATCH, 8'h01);
    set(M_FY, 1'b1);
    wt(3);
    rc(IDX_ALM_ISR, 8'h02);
    rc(IDX_ALM_ISR, 8'h02);
    ev(M_TICK, 1);
    ev(M_FAS, 1);
    rc(IDX_ALM_ISR, 8'h00);
    rc(IDX_FRAME_ERROR_COUNT_LO, 8'h01);
    wr(IDX_IRQ_EN, 8'h77);
    rc(IDX_IRQ_EN, 8'h77);
    set(M_FY, 1'b0);
    wt(3);
    rc(IDX_ALM_ISR, 8'h02);
    rc(IDX_ALM_ISR, 8'h00);
    late = 1'b1;
    wr(IDX_ACT_PAT, 8'h3C);
    rc(IDX_ACT_PAT, 8'h3C);
    late = 1'b0;
    rd(8'h30);
    chk("rresp", rsp, RESP_SLVERR);
    summarize;
  end

  // Whole run is under a thousand cycles
  initial begin
    wt(20000);
    fail_count++;
    summarize;
  end
endmodule
